// >>> rtl/operating_mode_scheduler.sv
// Operating word, configuration words, stored copies and the measurement scheduler.
// Assumes a command decoder, converter and FIFO on the same clock.
`timescale 1ns/1ps

module operating_mode_scheduler
	import operating_mode_pkg::*;
#(
	parameter logic [31:0] DELAY_CYC [16] = DELAY_CYC_DEF
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Command port
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic [7:0] cmdAddr,
	input wire logic [15:0] cmdData,
	output logic rspValid,
	output logic rspRefused,
	output logic [15:0] rspData,
	// Converter
	output logic convStart,
	output logic [1:0] convChannel,
	input wire logic convDone,
	output logic biasOn,
	output logic autoRunning,
	// FIFO and temperature routing
	output logic [1:0] fifoMode,
	output logic fifoReset,
	output logic tempSel,
	output logic [1:0] compTempChannel,
	input wire logic [5:0] fifoCount,
	output logic fifoAlert,
	// Interrupts and switch
	input wire logic globalIntEn,
	input wire logic [3:0] intCause,
	input wire logic thrLevel,
	input wire logic aboveHigh,
	input wire logic belowLow,
	output logic [3:0] intPending,
	output logic intPin,
	output logic switchOut
);

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT, ST_DELAY} state_e;

	typedef struct packed {
		state_e st;
		logic [15:0] operReg;
		logic [15:0] operAct;
		logic [2:0][15:0] cfgReg;
		logic [3:0][15:0] nvm;
		logic autoOn;
		logic stopReq;
		logic [1:0] phase;
		logic [31:0] delayCnt;
		logic [7:0] ratioCnt;
		logic convStart;
		logic rspValid;
		logic rspRefused;
		logic [15:0] rspData;
		logic [3:0] pending;
		logic intPin;
		logic fifoAlert;
		logic switchOut;
		logic biasOn;
	} state_s;

	state_s cur_reg;
	state_s cur_next;

	cmd_e cmd;
	logic fifoThrHit;
	logic [4:0] fifoThr;

	assign cmd = cmd_e'(cmdCode);
	assign fifoThr = cur_reg.operAct[POS_FIFO_THR +: 5];

	always_comb
	begin
		fifoThrHit = (fifoThr != 5'h0) && (fifoCount >= {1'b0, fifoThr});
	end

	always_comb
	begin
		logic blocked;
		logic clrPend;
		logic startSet;
		logic [3:0] dcode;
		blocked = 1'b0;
		clrPend = 1'b0;
		startSet = 1'b0;
		dcode = cur_reg.operReg[POS_DELAY +: 4];
		cur_next = cur_reg;
		cur_next.convStart = 1'b0;
		cur_next.rspValid = 1'b0;
		cur_next.rspRefused = 1'b0;
		cur_next.rspData = READ_ZERO;

		if (cmdValid)
		begin
			cur_next.rspValid = 1'b1;
			blocked = cur_reg.autoOn && (cmd == CMD_CONVERT || cmd == CMD_WR_REG
				|| cmd == CMD_WR_OPERATING_CONTROL_WORD || cmd == CMD_WR_CFG || cmd == CMD_RD_NVM
				|| cmd == CMD_WR_NVM);
			if (blocked)
				cur_next.rspRefused = 1'b1;
			else
			begin
				case (cmd)
					CMD_RD_REG, CMD_WR_REG:
					begin
						case (cmdAddr)
							OFS_OPERATING_CONTROL_WORD:
							begin
								cur_next.rspData = cur_reg.operReg;
								if (cmd == CMD_WR_REG)
									cur_next.operReg = cmdData;
							end
							OFS_CFG_P, OFS_CFG_T1, OFS_CFG_T2:
							begin
								cur_next.rspData = cur_reg.cfgReg[cmdAddr[1:0] - 2'd1];
								if (cmd == CMD_WR_REG)
									cur_next.cfgReg[cmdAddr[1:0] - 2'd1] = cmdData;
							end
							default:
								cur_next.rspRefused = 1'b1;
						endcase
					end
					CMD_RD_OPERATING_CONTROL_WORD:
						cur_next.rspData = cur_reg.operReg;
					CMD_WR_OPERATING_CONTROL_WORD:
						cur_next.operReg = cmdData;
					CMD_RD_CFG, CMD_WR_CFG:
					begin
						if (cmdAddr[1:0] > 2'd2)
							cur_next.rspRefused = 1'b1;
						else
						begin
							cur_next.rspData = cur_reg.cfgReg[cmdAddr[1:0]];
							if (cmd == CMD_WR_CFG)
								cur_next.cfgReg[cmdAddr[1:0]] = cmdData;
						end
					end
					CMD_RD_NVM:
						cur_next.rspData = cur_reg.nvm[cmdAddr[1:0]];
					CMD_WR_NVM:
						cur_next.nvm[cmdAddr[1:0]] = cmdData;
					CMD_START_AUTO:
					begin
						if (dcode == 4'h0 || cur_reg.autoOn)
							cur_next.rspRefused = 1'b1;
						else
						begin
							cur_next.autoOn = 1'b1;
							cur_next.stopReq = 1'b0;
							if (cur_reg.st == ST_IDLE)
								startSet = 1'b1;
						end
					end
					CMD_STOP_AUTO:
					begin
						cur_next.autoOn = 1'b0;
						if (cur_reg.st == ST_IDLE || cur_reg.st == ST_DELAY)
						begin
							cur_next.st = ST_IDLE;
							cur_next.ratioCnt = 8'h00;
						end
						else
							cur_next.stopReq = 1'b1;
					end
					CMD_CONVERT:
					begin
						if (cur_reg.st == ST_IDLE)
							startSet = 1'b1;
						else
							cur_next.rspRefused = 1'b1;
					end
					CMD_RD_STATUS:
					begin
						cur_next.rspData = {cur_reg.ratioCnt, cur_reg.pending,
							cur_reg.autoOn, cur_reg.stopReq, cur_reg.st};
						clrPend = 1'b1;
					end
					default:
						cur_next.rspRefused = 1'b1;
				endcase
			end
		end

		case (cur_reg.st)
			ST_IDLE:
			begin
				if (startSet)
					cur_next.st = ST_CONV;
			end
			ST_CONV:
			begin
				cur_next.convStart = 1'b1;
				cur_next.st = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (convDone)
				begin
					if (cur_reg.phase != CH_T2)
					begin
						cur_next.phase = cur_reg.phase + 2'd1;
						cur_next.st = ST_CONV;
					end
					else
					begin
						cur_next.phase = CH_P;
						// Next values, so a stop or start in this same cycle is not lost
						if (cur_next.stopReq || !cur_next.autoOn)
						begin
							cur_next.st = ST_IDLE;
							if (cur_next.stopReq)
								cur_next.ratioCnt = 8'h00;
							cur_next.stopReq = 1'b0;
						end
						else
						begin
							cur_next.ratioCnt = cur_reg.ratioCnt + 8'd1;
							cur_next.delayCnt = DELAY_CYC[cur_reg.operAct[POS_DELAY +: 4]];
							cur_next.st = ST_DELAY;
						end
					end
				end
			end
			ST_DELAY:
			begin
				if (!cur_next.autoOn)
					cur_next.st = ST_IDLE;
				else if (cur_reg.delayCnt <= 32'd1)
					cur_next.st = ST_CONV;
				else
					cur_next.delayCnt = cur_reg.delayCnt - 32'd1;
			end
			default:
				cur_next.st = ST_IDLE;
		endcase

		// Operating word latched at the start of a measurement set and on every cycle spent in idle
		if (cur_next.st == ST_CONV && cur_next.phase == CH_P && cur_reg.st != ST_WAIT)
			cur_next.operAct = cur_next.operReg;
		else if (cur_reg.st == ST_IDLE && cur_next.st == ST_IDLE)
			cur_next.operAct = cur_next.operReg;

		if (cur_reg.operAct[POS_INT_MODE])
		begin
			if (intCause != 4'h0)
				cur_next.pending = intCause;
			else if (clrPend)
				cur_next.pending = 4'h0;
		end
		else
			cur_next.pending = (cur_reg.pending & ~{4{clrPend}}) | intCause;

		cur_next.fifoAlert = globalIntEn && fifoThrHit;
		cur_next.intPin = globalIntEn && (cur_next.fifoAlert || (cur_reg.operAct[POS_CONT_MODE]
			? thrLevel : (cur_next.pending != 4'h0)));

		if (!cur_reg.operAct[POS_SWITCH_EN])
			cur_next.switchOut = 1'b0;
		else if (aboveHigh)
			cur_next.switchOut = 1'b1;
		else if (belowLow)
			cur_next.switchOut = 1'b0;

		cur_next.biasOn = cur_next.operAct[POS_FAST_START]
			|| cur_next.st == ST_CONV || cur_next.st == ST_WAIT;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur_reg <= '0;
			cur_reg.st <= ST_IDLE;
			cur_reg.operReg <= OPERATING_CONTROL_WORD_RESET;
			cur_reg.operAct <= OPERATING_CONTROL_WORD_RESET;
			cur_reg.cfgReg <= {3{CFG_RESET}};
			cur_reg.nvm <= {OPERATING_CONTROL_WORD_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
			cur_reg.phase <= CH_P;
		end
		else
			cur_reg <= cur_next;
	end

	assign rspValid = cur_reg.rspValid;
	assign rspRefused = cur_reg.rspRefused;
	assign rspData = cur_reg.rspData;
	assign convStart = cur_reg.convStart;
	assign convChannel = cur_reg.phase;
	assign biasOn = cur_reg.biasOn;
	assign autoRunning = cur_reg.autoOn;
	assign fifoMode = cur_reg.operAct[POS_FIFO_MODE +: 2];
	assign fifoReset = ~|cur_reg.operAct[POS_FIFO_MODE +: 2];
	assign tempSel = cur_reg.operAct[POS_TEMP_SEL];
	assign compTempChannel = CH_T1;
	assign fifoAlert = cur_reg.fifoAlert;
	assign intPending = cur_reg.pending;
	assign intPin = cur_reg.intPin;
	assign switchOut = cur_reg.switchOut;

	sequence s_set_done;
		cur_reg.st == ST_WAIT && convDone && cur_reg.phase == CH_T2;
	endsequence

	a_refuse_auto_write: assert property (@(posedge clk) disable iff (!rst_b)
		cmdValid && autoRunning && cmd == CMD_WR_OPERATING_CONTROL_WORD |=> rspValid && rspRefused)
		else $error("write accepted during automatic mode");
	a_start_needs_delay: assert property (@(posedge clk) disable iff (!rst_b)
		cmdValid && cmd == CMD_START_AUTO && cur_reg.operReg[POS_DELAY +: 4] == 4'h0
		|=> !autoRunning && rspRefused)
		else $error("start accepted with delay off");
	a_delay_from_end: assert property (@(posedge clk) disable iff (!rst_b)
		s_set_done ##0 cur_reg.autoOn && !cur_reg.stopReq
		&& !(cmdValid && cmd == CMD_STOP_AUTO) |=> cur_reg.st == ST_DELAY
		&& cur_reg.delayCnt == DELAY_CYC[cur_reg.operAct[POS_DELAY +: 4]])
		else $error("delay not loaded at set completion");
	a_stop_full_set: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.stopReq && cur_reg.st == ST_WAIT && convDone && cur_reg.phase != CH_T2
		|=> cur_reg.st == ST_CONV)
		else $error("set abandoned on stop");
	a_stop_ratio_clr: assert property (@(posedge clk) disable iff (!rst_b)
		s_set_done ##0 cur_reg.stopReq |=> cur_reg.st == ST_IDLE && cur_reg.ratioCnt == 8'h00)
		else $error("ratio counter not cleared on stop");
	a_fifo_alert_mask: assert property (@(posedge clk) disable iff (!rst_b)
		!globalIntEn |=> !fifoAlert && !intPin)
		else $error("interrupt not masked");
	a_fifo_alert_hit: assert property (@(posedge clk) disable iff (!rst_b)
		globalIntEn && fifoThrHit |=> fifoAlert)
		else $error("fifo alert missed");
	a_pending_or: assert property (@(posedge clk) disable iff (!rst_b)
		!cur_reg.operAct[POS_INT_MODE] && intCause != 4'h0
		|=> (intPending & $past(intCause)) == $past(intCause))
		else $error("interrupt cause lost");
	a_operating_control_word_held_conv: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.st == ST_WAIT && cur_next.st != ST_IDLE |=> $stable(cur_reg.operAct))
		else $error("operating word changed mid cycle");
	a_bias_off_idle: assert property (@(posedge clk) disable iff (!rst_b)
		cur_reg.st == ST_DELAY && !cur_reg.operAct[POS_FAST_START] |-> !biasOn)
		else $error("bias left on between measurements");

endmodule

// >>> shared/operating_mode_pkg.sv
// Constants for the operating-word scheduler: command codes, word layout,
// register offsets and delay timing. Assumes a 25 MHz system clock.
package operating_mode_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;

	// Register offsets seen by the register commands
	localparam logic [7:0] OFS_OPERATING_CONTROL_WORD = 8'h64;
	localparam logic [7:0] OFS_CFG_P = 8'h65;
	localparam logic [7:0] OFS_CFG_T1 = 8'h66;
	localparam logic [7:0] OFS_CFG_T2 = 8'h67;

	// Stored-copy slots for the memory commands
	localparam logic [1:0] NVM_OPERATING_CONTROL_WORD = 2'h0;
	localparam logic [1:0] NVM_CFG_P = 2'h1;
	localparam logic [1:0] NVM_CFG_T1 = 2'h2;
	localparam logic [1:0] NVM_CFG_T2 = 2'h3;

	// Operating word fields
	localparam int POS_INT_MODE = 15;
	localparam int POS_FAST_START = 14;
	localparam int POS_CONT_MODE = 13;
	localparam int POS_SWITCH_EN = 12;
	localparam int POS_TEMP_SEL = 11;
	localparam int POS_FIFO_THR = 6;
	localparam int POS_FIFO_MODE = 4;
	localparam int POS_DELAY = 0;
	localparam logic [15:0] OPERATING_CONTROL_WORD_RESET = 16'h0000;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// Measurement channels, one set is P then T1 then T2
	localparam logic [1:0] CH_P = 2'h0;
	localparam logic [1:0] CH_T1 = 2'h1;
	localparam logic [1:0] CH_T2 = 2'h2;

	typedef enum logic [3:0] {
		CMD_RD_REG = 4'h0,
		CMD_WR_REG = 4'h1,
		CMD_RD_OPERATING_CONTROL_WORD = 4'h2,
		CMD_WR_OPERATING_CONTROL_WORD = 4'h3,
		CMD_RD_CFG = 4'h4,
		CMD_WR_CFG = 4'h5,
		CMD_RD_NVM = 4'h6,
		CMD_WR_NVM = 4'h7,
		CMD_START_AUTO = 4'h8,
		CMD_STOP_AUTO = 4'h9,
		CMD_CONVERT = 4'hA,
		CMD_RD_STATUS = 4'hB
	} cmd_e;

	// Delay per code in microseconds; code 0 means off
	localparam longint unsigned DELAY_US [16] = '{
		0, 0, 1_000, 5_000, 10_000, 20_000, 50_000, 100_000,
		200_000, 500_000, 1_000_000, 2_000_000, 5_000_000, 10_000_000,
		20_000_000, 60_000_000
	};

	function automatic logic [31:0] us_to_cycles(input longint unsigned us);
		longint unsigned cyc;
		cyc = us * longint'(CLK_HZ) / 64'd1_000_000;
		return cyc[31:0];
	endfunction

	localparam logic [31:0] DELAY_CYC_DEF [16] = '{
		us_to_cycles(DELAY_US[0]), us_to_cycles(DELAY_US[1]),
		us_to_cycles(DELAY_US[2]), us_to_cycles(DELAY_US[3]),
		us_to_cycles(DELAY_US[4]), us_to_cycles(DELAY_US[5]),
		us_to_cycles(DELAY_US[6]), us_to_cycles(DELAY_US[7]),
		us_to_cycles(DELAY_US[8]), us_to_cycles(DELAY_US[9]),
		us_to_cycles(DELAY_US[10]), us_to_cycles(DELAY_US[11]),
		us_to_cycles(DELAY_US[12]), us_to_cycles(DELAY_US[13]),
		us_to_cycles(DELAY_US[14]), us_to_cycles(DELAY_US[15])
	};

endpackage

// >>> verif/conv_model.sv
// Converter stand-in: answers a start with one done pulse; a new start while counting restarts the count.
// Assumes the scheduler clock and its active-low reset.
`timescale 1ns/1ps
module conv_model
#(
	parameter int LAT = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Conversion handshake
	input wire logic convStart,
	output logic convDone
);
	int cnt;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 0;
			convDone <= 1'h0;
		end
		else
		begin
			convDone <= (cnt == 1);
			if (convStart)
				cnt <= LAT;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the operating-word scheduler.
// Assumes the package, the design and the converter stand-in compile first.
`timescale 1ns/1ps
module tb_top;
	import operating_mode_pkg::*;
	localparam logic [31:0] DCYC [16] = '{0, 0, 10, 20, 30, 40, 50, 60, 70, 80, 90, 100,
		110, 120, 130, 140};
	localparam int LIMIT = 5000;
	logic clk, rst_b, cmdValid, rspValid, rspRefused, convStart, convDone, biasOn;
	logic autoRunning, fifoReset, tempSel, fifoAlert, globalIntEn, thrLevel;
	logic aboveHigh, belowLow, intPin, switchOut, refused;
	logic [3:0] cmdCode, intCause, intPending;
	logic [7:0] cmdAddr, v;
	logic [15:0] cmdData, rspData, rd;
	logic [1:0] convChannel, fifoMode, compTempChannel;
	logic [5:0] fifoCount;
	int n_errors, n_compared, cyc, nStart, t0;

	operating_mode_scheduler #(.DELAY_CYC(DCYC)) dut (.clk, .rst_b, .cmdValid, .cmdCode,
		.cmdAddr, .cmdData, .rspValid, .rspRefused, .rspData, .convStart, .convChannel,
		.convDone, .biasOn, .autoRunning, .fifoMode, .fifoReset, .tempSel, .compTempChannel,
		.fifoCount, .fifoAlert, .globalIntEn, .intCause, .thrLevel, .aboveHigh, .belowLow,
		.intPending, .intPin, .switchOut);
	conv_model #(.LAT(4)) conv (.clk, .rst_b, .convStart, .convDone);

	task automatic end_sim;
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic cmd(input cmd_e c, input logic [7:0] a, input logic [15:0] d);
		int i;
		cmdValid = 1'h1;
		cmdCode = c;
		cmdAddr = a;
		cmdData = d;
		tick(1);
		cmdValid = 1'h0;
		i = 0;
		while (rspValid !== 1'h1 && i < 4)
		begin
			tick(1);
			i++;
		end
		chk(rspValid, 1'h1, "no answer");
		refused = rspRefused;
		rd = rspData;
		tick(1);
	endtask

	task automatic wstart(input logic [1:0] ch);
		int i;
		i = 0;
		while (convStart !== 1'h1 && i < 200)
		begin
			tick(1);
			i++;
		end
		chk(convStart, 1'h1, "start seen");
		chk(convChannel, ch, "channel order");
	endtask

	task automatic t_regs;
		cmd(CMD_RD_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		chk(rd, OPERATING_CONTROL_WORD_RESET, "reset word");
		chk({fifoReset, compTempChannel, biasOn, autoRunning}, 5'h14, "reset outs");
		cmd(CMD_WR_REG, OFS_OPERATING_CONTROL_WORD, 16'h1230);
		cmd(CMD_RD_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		chk(rd, 16'h1230, "reg to operating_control_word");
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0C40);
		cmd(CMD_RD_REG, OFS_OPERATING_CONTROL_WORD, 16'h0000);
		chk(rd, 16'h0C40, "operating_control_word to reg");
		cmd(CMD_WR_NVM, {6'h00, NVM_OPERATING_CONTROL_WORD}, 16'hA5A0);
		cmd(CMD_RD_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		chk(rd, 16'h0C40, "copy apart");
		cmd(CMD_RD_NVM, {6'h00, NVM_OPERATING_CONTROL_WORD}, 16'h0000);
		chk(rd, 16'hA5A0, "stored copy");
		for (int k = 0; k < 3; k++)
		begin
			cmd(CMD_WR_CFG, 8'(k), 16'hC0D0 + 16'(k));
			cmd(CMD_RD_REG, OFS_CFG_P + 8'(k), 16'h0000);
			chk(rd, 16'hC0D0 + 16'(k), "cfg by reg");
			cmd(CMD_WR_NVM, {6'h00, NVM_CFG_P + 2'(k)}, 16'h0F00 + 16'(k));
			cmd(CMD_RD_CFG, 8'(k), 16'h0000);
			chk(rd, 16'hC0D0 + 16'(k), "cfg by cfg");
			cmd(CMD_RD_NVM, {6'h00, NVM_CFG_P + 2'(k)}, 16'h0000);
			chk(rd, 16'h0F00 + 16'(k), "cfg copy");
		end
		cmd(CMD_RD_REG, 8'h70, 16'h0000);
		chk(refused, 1'h1, "unmapped");
		cmd(CMD_RD_CFG, 8'h03, 16'h0000);
		chk(refused, 1'h1, "cfg index 3");
		$display("t_regs done");
	endtask

	task automatic t_fields;
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h5820);
		aboveHigh = 1'h1;
		tick(3);
		v = {biasOn, tempSel, fifoMode, fifoReset, compTempChannel, switchOut};
		chk(v, 8'hE3, "fields on");
		aboveHigh = 1'h0;
		tick(3);
		chk(switchOut, 1'h1, "switch holds");
		belowLow = 1'h1;
		tick(3);
		chk(switchOut, 1'h0, "switch low");
		belowLow = 1'h0;
		aboveHigh = 1'h1;
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		tick(3);
		v = {biasOn, tempSel, fifoMode, fifoReset, compTempChannel, switchOut};
		chk(v, 8'h0A, "fields off");
		aboveHigh = 1'h0;
		for (int m = 1; m < 4; m++)
		begin
			cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'(m) << 4);
			tick(2);
			chk({fifoMode, fifoReset}, {2'(m), 1'h0}, "fifo mode");
		end
		$display("t_fields done");
	endtask

	task automatic al(input logic [15:0] w, input logic [5:0] n, input logic g, input logic e);
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, w);
		fifoCount = n;
		globalIntEn = g;
		tick(3);
		chk(fifoAlert, e, "fifo alert");
	endtask

	task automatic t_alert;
		al(16'h00D0, 6'h02, 1'h1, 1'h0);
		al(16'h00D0, 6'h03, 1'h1, 1'h1);
		al(16'h00D0, 6'h03, 1'h0, 1'h0);
		al(16'h0050, 6'h01, 1'h1, 1'h1);
		al(16'h07D0, 6'h1E, 1'h1, 1'h0);
		al(16'h07D0, 6'h1F, 1'h1, 1'h1);
		al(16'h0010, 6'h20, 1'h1, 1'h0);
		fifoCount = 6'h00;
		$display("t_alert done");
	endtask

	task automatic pulse(input logic [3:0] c);
		intCause = c;
		tick(1);
		intCause = 4'h0;
		tick(2);
	endtask

	task automatic t_int;
		globalIntEn = 1'h1;
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		cmd(CMD_RD_STATUS, 8'h00, 16'h0000);
		pulse(4'h1);
		pulse(4'h2);
		chk(intPending, 4'h3, "or mode");
		chk(intPin, 1'h1, "pin pending");
		globalIntEn = 1'h0;
		tick(2);
		chk(intPin, 1'h0, "pin masked");
		globalIntEn = 1'h1;
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h8000);
		cmd(CMD_RD_STATUS, 8'h00, 16'h0000);
		pulse(4'h1);
		pulse(4'h2);
		chk(intPending, 4'h2, "update mode");
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h2000);
		cmd(CMD_RD_STATUS, 8'h00, 16'h0000);
		chk(intPending, 4'h0, "cleared");
		thrLevel = 1'h1;
		tick(2);
		chk(intPin, 1'h1, "cont high");
		thrLevel = 1'h0;
		tick(2);
		chk(intPin, 1'h0, "cont low");
		$display("t_int done");
	endtask

	task automatic t_auto;
		cmd_e bad [6] = '{CMD_CONVERT, CMD_WR_REG, CMD_WR_OPERATING_CONTROL_WORD, CMD_WR_CFG, CMD_RD_NVM,
			CMD_WR_NVM};
		int i, n0;
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		cmd(CMD_START_AUTO, 8'h00, 16'h0000);
		chk({refused, autoRunning}, 2'h2, "start with delay off");
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0003);
		cmd(CMD_START_AUTO, 8'h00, 16'h0000);
		chk({refused, autoRunning}, 2'h1, "start");
		foreach (bad[k])
		begin
			cmd(bad[k], bad[k] == CMD_WR_REG ? OFS_OPERATING_CONTROL_WORD : 8'h00, 16'h0000);
			chk(refused, 1'h1, "refused while auto");
		end
		cmd(CMD_RD_OPERATING_CONTROL_WORD, 8'h00, 16'h0000);
		chk(refused, 1'h0, "read while auto");
		chk(rd, 16'h0003, "read data while auto");
		i = 0;
		while (!(convDone === 1'h1 && convChannel === CH_T2) && i < 200)
		begin
			tick(1);
			i++;
		end
		t0 = cyc;
		tick(1);
		wstart(CH_P);
		chk(cyc - t0 >= DCYC[3] - 1 && cyc - t0 <= DCYC[3] + 5, 1'h1, "gap");
		n0 = nStart;
		cmd(CMD_STOP_AUTO, 8'h00, 16'h0000);
		chk(refused, 1'h0, "stop");
		tick(80);
		chk(16'(nStart - n0), 16'h0003, "set completed");
		chk({autoRunning, convChannel}, 3'h0, "idle after set");
		cmd(CMD_RD_STATUS, 8'h00, 16'h0000);
		chk(rd[15:8], 8'h00, "ratio reset");
		n0 = nStart;
		cmd(CMD_CONVERT, 8'h00, 16'h0000);
		chk(refused, 1'h0, "convert when idle");
		cmd(CMD_WR_OPERATING_CONTROL_WORD, 8'h00, 16'h0800);
		tick(2);
		chk(tempSel, 1'h0, "word held mid set");
		tick(30);
		chk(16'(nStart - n0), 16'h0003, "digital set");
		chk(tempSel, 1'h1, "word after set");
		$display("t_auto done");
	endtask

	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (convStart === 1'h1)
			nStart <= nStart + 1;
		if (cyc >= LIMIT)
		begin
			n_errors++;
			end_sim();
		end
	end

	initial
	begin
		rst_b = 1'h0;
		cmdValid = 1'h0;
		cmdCode = 4'h0;
		cmdAddr = 8'h00;
		cmdData = 16'h0000;
		globalIntEn = 1'h0;
		intCause = 4'h0;
		thrLevel = 1'h0;
		aboveHigh = 1'h0;
		belowLow = 1'h0;
		fifoCount = 6'h00;
		tick(8);
		rst_b = 1'h1;
		tick(1);
		t_regs();
		t_fields();
		t_alert();
		t_int();
		t_auto();
		end_sim();
	end
endmodule
